// ==== rtl/dram_ctrl_pkg.sv ====
package dram_ctrl_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 25000;
  localparam int ROW_HOLD_NS = 20;
  localparam int RCD_NS = 30;
  localparam int CAS_WIDTH_NS = 100;
  localparam int RAS_WIDTH_NS = 150;
  localparam int RAS_PRECHARGE_NS = 100;
  localparam int COLUMN_PRECHARGE_NS = 60;
  localparam int COLUMN_TO_WRITE_DELAY_NS = 60;
  localparam int ROW_TO_WRITE_DELAY_NS = 110;
  localparam int WRITE_PULSE_NS = 45;
  localparam int ROW_ACCESS_TIME_NS = 150;
  localparam int COLUMN_ACCESS_TIME_NS = 100;
  localparam int REFRESH_INTERVAL_US = 2000;
  localparam int REFRESH_ROWS = 64;
  localparam int POWERUP_REFRESHES = 8;

  // Least times round up to whole cycles
  localparam int ROW_HOLD_CYC = (ROW_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RCD_CYC = (RCD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CAS_WIDTH_CYC = (CAS_WIDTH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RAS_WIDTH_CYC = (RAS_WIDTH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RAS_PRE_CYC = (RAS_PRECHARGE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CAS_PRE_CYC =
    (COLUMN_PRECHARGE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CWD_CYC =
    (COLUMN_TO_WRITE_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RWD_CYC =
    (ROW_TO_WRITE_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WP_CYC = (WRITE_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CAC_CYC =
    (COLUMN_ACCESS_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RAC_CYC = (ROW_ACCESS_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Longest time rounds down: refresh interval spread over all rows
  localparam int REFRESH_SPACING_CYC =
    (REFRESH_INTERVAL_US * 1000000 / REFRESH_ROWS) / CLK_PERIOD_PS;

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int HALF_W = 6;
  localparam int TIMER_W = 8;
  localparam logic [HALF_W-1:0] REFRESH_ROW_RESET = 6'h00;

  typedef enum logic [1:0] {
    OP_READ,
    OP_EARLY_WRITE,
    OP_READ_MODIFY_WRITE
  } op_kind_t;

endpackage

// ==== rtl/dram_timer.sv ====
module dram_timer
  import dram_ctrl_pkg::*;
#(
  parameter int W = TIMER_W
) (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic load_i,
  input wire logic [W-1:0] count_i,
  output logic done_o
);

  logic [W-1:0] count_reg;

  assign done_o = (count_reg == '0);

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      count_reg <= '0;
    end else if (ce_i) begin
      if (load_i) begin
        count_reg <= count_i;
      end else if (count_reg != '0) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule

// ==== rtl/dram_ctrl.sv ====
module dram_ctrl
  import dram_ctrl_pkg::*;
#(
  parameter int REFRESH_SPACING = REFRESH_SPACING_CYC
) (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic req_valid_i,
  input wire logic [1:0] req_kind_i,
  input wire logic [ADDR_W-1:0] req_addr_i,
  input wire logic req_deselect_i,
  input wire logic req_page_i,
  input wire logic req_wdata_i,
  output logic req_ready_o,
  output logic rsp_valid_o,
  output logic rsp_data_o,
  output logic init_done_o,
  output logic row_strobe_n_o,
  output logic column_strobe_n_o,
  output logic write_enable_n_o,
  output logic chip_select_n_o,
  output logic [HALF_W-1:0] mux_address_pins_o,
  output logic write_data_pin_o,
  input wire logic read_data_pin_i
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum {
    ST_IDLE, ST_ROW, ST_RCD, ST_CAS, ST_WE, ST_CAS_END,
    ST_PAGE, ST_RAS_END, ST_PRECHARGE
  } state_t;

  state_t state_reg, state_next;
  logic [HALF_W-1:0] col_reg;
  logic [HALF_W-1:0] row_reg;
  logic [HALF_W-1:0] refresh_row_reg;
  logic [3:0] init_cnt_reg;
  logic [31:0] refresh_cnt_reg;
  logic refresh_due_reg;
  logic refreshing_reg;
  logic [1:0] kind_reg;
  logic desel_reg;
  logic timer_load;
  logic [TIMER_W-1:0] timer_count;
  logic timer_done;

  dram_timer #(.W(TIMER_W)) u_timer (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .load_i(timer_load),
    .count_i(timer_count),
    .done_o(timer_done)
  );

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire init_busy = (init_cnt_reg != 4'(POWERUP_REFRESHES));
  wire want_refresh = refresh_due_reg || init_busy;
  wire take_req = req_valid_i && req_ready_o;
  wire is_read = (kind_reg == 2'(OP_READ));
  wire is_early = (kind_reg == 2'(OP_EARLY_WRITE));
  wire is_rmw = (kind_reg == 2'(OP_READ_MODIFY_WRITE));
  // Delayed write waits past both column and row delay minima
  wire [TIMER_W-1:0] rmw_wait = TIMER_W'((CWD_CYC > (RWD_CYC - RCD_CYC - ROW_HOLD_CYC)) ?
    CWD_CYC : (RWD_CYC - RCD_CYC - ROW_HOLD_CYC));
  // Read sample after column access time and column strobe width have both elapsed
  wire [TIMER_W-1:0] cas_hold = TIMER_W'((CAC_CYC > CAS_WIDTH_CYC) ?
    CAC_CYC : CAS_WIDTH_CYC);
  wire page_next = req_valid_i && req_page_i && (req_addr_i[ADDR_W-1:HALF_W] == row_reg) &&
    !want_refresh;

  always_comb begin
    state_next = state_reg;
    timer_load = 1'b0;
    timer_count = '0;
    case (state_reg)
      ST_IDLE: begin
        if (want_refresh || take_req) begin
          state_next = ST_ROW;
          timer_load = 1'b1;
          timer_count = TIMER_W'(ROW_HOLD_CYC);
        end
      end
      ST_ROW: begin
        if (timer_done) begin
          state_next = refreshing_reg ? ST_RAS_END : ST_RCD;
          timer_load = 1'b1;
          timer_count = refreshing_reg ? TIMER_W'(RAS_WIDTH_CYC) : TIMER_W'(RCD_CYC);
        end
      end
      ST_RCD: begin
        if (timer_done) begin
          state_next = ST_CAS;
          timer_load = 1'b1;
          timer_count = is_rmw ? rmw_wait : cas_hold;
        end
      end
      ST_CAS: begin
        if (timer_done) begin
          state_next = is_rmw ? ST_WE : ST_CAS_END;
          timer_load = is_rmw;
          timer_count = TIMER_W'(WP_CYC);
        end
      end
      ST_WE: begin
        if (timer_done) begin
          state_next = ST_CAS_END;
        end
      end
      ST_CAS_END: begin
        state_next = ST_PAGE;
        timer_load = 1'b1;
        timer_count = TIMER_W'(CAS_PRE_CYC);
      end
      ST_PAGE: begin
        // Same-row request taken here goes straight to the column half
        if (take_req) begin
          state_next = ST_RCD;
          timer_load = 1'b1;
          timer_count = TIMER_W'(RCD_CYC);
        end else if (timer_done && !page_next) begin
          state_next = ST_RAS_END;
        end
      end
      ST_RAS_END: begin
        if (timer_done) begin
          state_next = ST_PRECHARGE;
          timer_load = 1'b1;
          timer_count = TIMER_W'(RAS_PRE_CYC);
        end
      end
      ST_PRECHARGE: begin
        if (timer_done) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  wire ready_next = ce_i && ((state_next == ST_IDLE && !want_refresh) ||
    (state_next == ST_PAGE && page_next));
  wire latch_req = take_req && ((state_reg == ST_IDLE) || (state_reg == ST_PAGE));
  // A request already accepted beats a refresh that became due meanwhile
  wire start_refresh = (state_reg == ST_IDLE) && want_refresh && !take_req;

  // ----------------------------------------------------------------
  // Sequencer and request capture
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg <= ST_IDLE;
      req_ready_o <= 1'b0;
      kind_reg <= 2'h0;
      desel_reg <= 1'b1;
      refreshing_reg <= 1'b0;
      row_reg <= '0;
      col_reg <= '0;
      write_data_pin_o <= 1'b0;
    end else if (ce_i) begin
      state_reg <= state_next;
      req_ready_o <= ready_next;
      if (start_refresh) begin
        refreshing_reg <= 1'b1;
        row_reg <= refresh_row_reg;
      end else if (latch_req) begin
        refreshing_reg <= 1'b0;
        kind_reg <= req_kind_i;
        desel_reg <= req_deselect_i;
        row_reg <= req_addr_i[ADDR_W-1:HALF_W];
        col_reg <= req_addr_i[HALF_W-1:0];
        write_data_pin_o <= req_wdata_i;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  wire ras_low = !(state_next == ST_IDLE || state_next == ST_PRECHARGE);
  wire cas_low = (state_next == ST_CAS || state_next == ST_WE);
  // Kind of the access that the next pin state belongs to
  wire early_now = latch_req ? (req_kind_i == 2'(OP_EARLY_WRITE)) : is_early;
  // Early write asserts before column falls; delayed write after wait
  wire we_low = !refreshing_reg && ((early_now && (state_next == ST_RCD || cas_low)) ||
    (is_rmw && state_next == ST_WE));
  wire [HALF_W-1:0] addr_next = (state_next == ST_ROW || state_next == ST_IDLE) ?
    ((start_refresh) ? refresh_row_reg : (latch_req ? req_addr_i[ADDR_W-1:HALF_W] : row_reg)) :
    col_reg;
  wire sample_read = (state_reg == ST_CAS) && timer_done && (is_read || is_rmw) && !desel_reg;
  // Select level follows the access from its first pin edge on
  wire cs_n_next = start_refresh || (latch_req ? req_deselect_i : (desel_reg || refreshing_reg));

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      row_strobe_n_o <= 1'b1;
      column_strobe_n_o <= 1'b1;
      write_enable_n_o <= 1'b1;
      chip_select_n_o <= 1'b1;
      mux_address_pins_o <= '0;
      rsp_valid_o <= 1'b0;
      rsp_data_o <= 1'b0;
    end else if (ce_i) begin
      row_strobe_n_o <= !ras_low;
      column_strobe_n_o <= !cas_low;
      write_enable_n_o <= !we_low;
      chip_select_n_o <= cs_n_next;
      mux_address_pins_o <= addr_next;
      rsp_valid_o <= sample_read || ((state_reg == ST_CAS_END) && is_early);
      if (sample_read) begin
        rsp_data_o <= read_data_pin_i;
      end
    end
  end

  // ----------------------------------------------------------------
  // Refresh scheduling
  // ----------------------------------------------------------------
  wire refresh_done = refreshing_reg && (state_reg == ST_RAS_END) && timer_done;

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      refresh_row_reg <= REFRESH_ROW_RESET;
      refresh_cnt_reg <= '0;
      refresh_due_reg <= 1'b0;
      init_cnt_reg <= 4'h0;
      init_done_o <= 1'b0;
    end else if (ce_i) begin
      if (refresh_cnt_reg >= 32'(REFRESH_SPACING - 1)) begin
        refresh_cnt_reg <= '0;
      end else begin
        refresh_cnt_reg <= refresh_cnt_reg + 32'h1;
      end
      if (refresh_cnt_reg >= 32'(REFRESH_SPACING - 1)) begin
        refresh_due_reg <= 1'b1;
      end else if (refresh_done) begin
        refresh_due_reg <= 1'b0;
      end
      if (refresh_done) begin
        refresh_row_reg <= refresh_row_reg + 6'h01;
        if (init_busy) begin
          init_cnt_reg <= init_cnt_reg + 4'h1;
        end
      end
      init_done_o <= !init_busy;
    end
  end

endmodule

// ==== tb/dram_ctrl_checker.sv ====
module dram_ctrl_checker
  import dram_ctrl_pkg::*;
#(
  parameter int REFRESH_SPACING = REFRESH_SPACING_CYC
) (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic req_valid_i,
  input wire logic [1:0] req_kind_i,
  input wire logic [ADDR_W-1:0] req_addr_i,
  input wire logic req_deselect_i,
  input wire logic req_wdata_i,
  input wire logic req_ready_o,
  input wire logic rsp_valid_o,
  input wire logic init_done_o,
  input wire logic row_strobe_n_o,
  input wire logic column_strobe_n_o,
  input wire logic write_enable_n_o,
  input wire logic chip_select_n_o,
  input wire logic [HALF_W-1:0] mux_address_pins_o,
  input wire logic write_data_pin_o
);
  logic pend_reg, row_d_reg, sel_reg, wd_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [1:0] kind_reg;
  logic [15:0] since_reg;
  wire logic take = ce_i && req_valid_i && req_ready_o;
  wire logic row_fall = row_d_reg && !row_strobe_n_o;
  // Remember the request until its column strobe falls
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pend_reg <= 1'b0;
      row_d_reg <= 1'b1;
      sel_reg <= 1'b1;
      wd_reg <= 1'b0;
      addr_reg <= '0;
      kind_reg <= 2'h0;
      since_reg <= 16'h0000;
    end else begin
      row_d_reg <= row_strobe_n_o;
      pend_reg <= take || (pend_reg && column_strobe_n_o);
      since_reg <= row_fall ? 16'h0000 : since_reg + 16'(since_reg != 16'hffff);
      if (take) begin
        addr_reg <= req_addr_i;
        kind_reg <= req_kind_i;
        sel_reg <= req_deselect_i;
        wd_reg <= req_wdata_i;
      end
    end
  end
  default clocking dc @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_b_i);
  property p_row;
    $fell(row_strobe_n_o) && pend_reg |-> mux_address_pins_o == addr_reg[11:6];
  endproperty
  a_row: assert property (p_row) else $error("row half wrong");
  property p_col;
    $fell(column_strobe_n_o) && pend_reg |->
      mux_address_pins_o == addr_reg[5:0] && chip_select_n_o == sel_reg;
  endproperty
  a_col: assert property (p_col) else $error("column half or select wrong");
  property p_wd;
    $fell(write_enable_n_o) |-> write_data_pin_o == wd_reg;
  endproperty
  a_wd: assert property (p_wd) else $error("write data wrong");
  property p_early;
    $fell(column_strobe_n_o) && pend_reg && kind_reg == OP_EARLY_WRITE |-> !write_enable_n_o;
  endproperty
  a_early: assert property (p_early) else $error("early write late");
  property p_late;
    $fell(column_strobe_n_o) && kind_reg == OP_READ_MODIFY_WRITE |-> write_enable_n_o[*3];
  endproperty
  a_late: assert property (p_late) else $error("delayed write early");
  property p_read;
    !column_strobe_n_o && kind_reg == OP_READ |-> write_enable_n_o;
  endproperty
  a_read: assert property (p_read) else $error("write low in read");
  property p_rdy;
    req_ready_o |-> init_done_o;
  endproperty
  a_rdy: assert property (p_rdy) else $error("ready before init");
  property p_ref;
    row_fall && !pend_reg |-> chip_select_n_o && column_strobe_n_o && since_reg > 0;
  endproperty
  a_ref: assert property (p_ref) else $error("refresh not row only");
  property p_gap;
    since_reg < 16'(2 * REFRESH_SPACING);
  endproperty
  a_gap: assert property (p_gap) else $error("refresh overdue");
  c_page: cover property (take && !row_strobe_n_o);
  c_rsp: cover property (rsp_valid_o);
  c_desel: cover property ($fell(column_strobe_n_o) && chip_select_n_o);
endmodule

bind dram_ctrl dram_ctrl_checker #(.REFRESH_SPACING(REFRESH_SPACING)) u_chk (
  .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .req_valid_i(req_valid_i),
  .req_kind_i(req_kind_i), .req_addr_i(req_addr_i), .req_deselect_i(req_deselect_i),
  .req_wdata_i(req_wdata_i), .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
  .init_done_o(init_done_o), .row_strobe_n_o(row_strobe_n_o),
  .column_strobe_n_o(column_strobe_n_o), .write_enable_n_o(write_enable_n_o),
  .chip_select_n_o(chip_select_n_o), .mux_address_pins_o(mux_address_pins_o),
  .write_data_pin_o(write_data_pin_o));

// ==== tb/dram_model.sv ====
module dram_model #(
  parameter int ACCESS_NS = 90
) (
  input wire logic row_n_i,
  input wire logic col_n_i,
  input wire logic we_n_i,
  input wire logic cs_n_i,
  input wire logic [5:0] addr_i,
  input wire logic wdata_i,
  output logic rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic mem [0:4095];
  logic [5:0] row_reg, col_reg;
  logic cs_reg, act_reg, drv_reg, val_reg;
  // Released output shows the inverse of the last value
  assign rdata_o = drv_reg ? val_reg : ~val_reg;
  initial begin
    drv_reg = 1'b0;
    val_reg = 1'b0;
    foreach (mem[i]) mem[i] = 1'b0;
  end
  // Sample just after the strobe edge: address and strobe change together
  always @(negedge row_n_i) begin
    #1 row_reg = addr_i;
  end
  always @(negedge col_n_i) begin
    col_reg = addr_i;
    cs_reg = cs_n_i;
    act_reg = !row_n_i;
    drv_reg = 1'b0;
    val_reg = mem[{row_reg, col_reg}];
    if (act_reg && !cs_reg && !we_n_i) begin
      mem[{row_reg, col_reg}] = wdata_i;
      val_reg = wdata_i;
    end
    #ACCESS_NS drv_reg = act_reg && !cs_reg;
  end
  always @(negedge we_n_i) begin
    if (!row_n_i && !col_n_i && !cs_reg) mem[{row_reg, col_reg}] = wdata_i;
  end
endmodule

// ==== tb/dram_ctrl_test.sv ====
module dram_ctrl_test
  import dram_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_b = 1'b0, valid = 1'b0, desel = 1'b0, page = 1'b0, wd = 1'b0;
  logic ce = 1'b1;
  logic [1:0] kind = 2'h0;
  logic [11:0] addr = 12'h000;
  logic ready, rv, rd, init_done, row_n, col_n, we_n, cs_n, wpin, rpin;
  logic [5:0] pins;
  int n_mismatch = 0;
  int check_count = 0;
  bit shadow [int];
  dram_ctrl #(.REFRESH_SPACING(200)) DUT (
    .clk_sys_i(clk), .rst_b_i(rst_b), .ce_i(ce), .req_valid_i(valid),
    .req_kind_i(kind), .req_addr_i(addr), .req_deselect_i(desel), .req_page_i(page),
    .req_wdata_i(wd), .req_ready_o(ready), .rsp_valid_o(rv), .rsp_data_o(rd),
    .init_done_o(init_done), .row_strobe_n_o(row_n), .column_strobe_n_o(col_n),
    .write_enable_n_o(we_n), .chip_select_n_o(cs_n), .mux_address_pins_o(pins),
    .write_data_pin_o(wpin), .read_data_pin_i(rpin));
  dram_model u_mem (.row_n_i(row_n), .col_n_i(col_n), .we_n_i(we_n), .cs_n_i(cs_n),
    .addr_i(pins), .wdata_i(wpin), .rdata_o(rpin));
  initial forever #12.5 clk = ~clk;
  // Occasional frozen cycles
  initial forever begin
    @(posedge clk);
    #1 ce = ($urandom_range(15) != 0);
  end
  task automatic check(input string what, input logic seen, input logic exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %b seen %b", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic bail();
    n_mismatch++;
    print_verdict();
  endtask
  // One request: wait for take, then for the answer
  task automatic op(input logic [1:0] k, input logic [11:0] a, input logic d, input logic s,
                    input logic p);
    logic got, data, exp;
    int i;
    got = 1'b0;
    data = 1'b0;
    exp = (k == 2'h1) || !s;
    kind = k;
    addr = a;
    wd = d;
    desel = s;
    page = p;
    valid = 1'b1;
    for (i = 0; i < 400; i++) begin
      @(posedge clk);
      if (ready === 1'b1 && ce === 1'b1) break;
    end
    if (i == 400) bail();
    #1 valid = 1'b0;
    for (i = 0; i < 100; i++) begin
      @(posedge clk);
      if (rv === 1'b1) {got, data} = {1'b1, rd};
      if (got || (!exp && ready === 1'b1)) break;
    end
    if (i == 100) bail();
    #1;
    check("response", got, exp);
    if (got && k != 2'h1 && shadow.exists(a)) check("read data", data, shadow[a]);
    if (!s && k != 2'h0) shadow[a] = d;
  endtask
  initial begin
    int i;
    logic [1:0] k;
    void'($urandom(32'hc38e));
    repeat (16) @(posedge clk);
    #1 rst_b = 1'b1;
    for (i = 0; i < 3000 && init_done !== 1'b1; i++) @(posedge clk);
    #1 check("init done", init_done, 1'b1);
    op(2'h1, 12'hfff, 1'b1, 1'b0, 1'b1);
    op(2'h0, 12'hfff, 1'b0, 1'b0, 1'b1);
    op(2'h2, 12'hfff, 1'b0, 1'b1, 1'b0);
    op(2'h0, 12'hfff, 1'b0, 1'b0, 1'b0);
    op(2'h2, 12'h000, 1'b1, 1'b0, 1'b1);
    op(2'h2, 12'h000, 1'b0, 1'b0, 1'b0);
    for (i = 0; i < 80; i++) begin
      k = 2'($urandom_range(2));
      op(k, 12'($urandom_range(7)) ^ ($urandom_range(1) ? 12'hfff : 12'h000),
         1'($urandom_range(1)), k != 2'h1 && $urandom_range(3) == 0, 1'($urandom_range(1)));
    end
    print_verdict();
  end
endmodule
